// File: hw/mtcs_pkg.sv
// Shared constants and types for the multi-trigger capture sequencer.
// Assumes a single 125 MHz core clock; the cycles per millisecond are derived here.
package mtcs_pkg;
  localparam int          MTCS_CLK_HZ       = 125000000;
  localparam int          MTCS_MAX_BLOCKS   = 32;
  localparam int          MTCS_MAX_CORES    = 8;
  localparam int          MTCS_TMO_MAX_S    = 60;
  localparam logic [5:0]  MTCS_TMO_RST_S    = 6'h0a;
  localparam int          MTCS_MS_CYC       = MTCS_CLK_HZ / 1000;
  localparam int          MTCS_START_POS    = 0;
  // Register offsets.
  localparam logic [3:0]  MTCS_REG_CTRL     = 4'h0;
  localparam logic [3:0]  MTCS_REG_CFG      = 4'h1;
  localparam logic [3:0]  MTCS_REG_STAT     = 4'h2;
  localparam logic [3:0]  MTCS_REG_TMO      = 4'h3;
  // CTRL bit positions (write one to act).
  localparam int          MTCS_CTRL_START   = 0;
  localparam int          MTCS_CTRL_ABORT   = 1;
  localparam int          MTCS_CTRL_ERRCLR  = 2;
  // CFG field positions and reset value.
  localparam int          MTCS_CFG_NBLK_LSB = 0;
  localparam int          MTCS_CFG_MULTI    = 6;
  localparam int          MTCS_CFG_PAR      = 7;
  localparam int          MTCS_CFG_LIVE     = 8;
  localparam int          MTCS_CFG_PRE      = 9;
  localparam int          MTCS_CFG_MULTIIN  = 10;
  localparam int          MTCS_CFG_CORES    = 11;
  localparam logic [13:0] MTCS_CFG_RST      = 14'h0042;
  typedef enum logic [5:0] {
    MTCS_IDLE = 6'h01,
    MTCS_WAIT = 6'h02,
    MTCS_CAPT = 6'h04,
    MTCS_POST = 6'h08,
    MTCS_DONE = 6'h10,
    MTCS_FAIL = 6'h20
  } mtcs_state_t;
endpackage

// File: hw/mtcs_top.sv
// Capture sequencer: steps a flow of capture task blocks, one per trigger.
// Assumes step inputs come from pins (synchronised here), capture and task
// completion come from logic on core_clk, and software uses the plain port.
//
// Operation
// - One block per accepted step, in order.
// - Pending block waits, runs nothing, until timeout.
// - After last block, run post items untriggered.
// - Step from parallel or fieldbus; ready on both.
// - Other start sources run whole flow automatically.
// - Step while not ready: error, end unmeasured; a step during post items is ignored.
// - Block captures first, then processes.
// - One start item at position zero, one end.
// - One to thirty-two task blocks.
// - Items before first task are skipped.
// - Several inputs per block force non-multi mode.
// - Parallel: blocks concurrent up to core count.
// - Not parallel: blocks strictly one after another.
// - Live through-view runs flow automatically.
// - Branches stay inside their own block.
// - Timeout zero to sixty seconds, default ten, NG.
// - Non-multi applies camera settings each input.
// - Ready drops on step, returns after capture.
//
// The strobed register port and the placing of the registers are this design's own decisions.
module mtcs_top
  import mtcs_pkg::*;
#(
  parameter int MsCycles = MTCS_MS_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  input  wire logic        stepPin,
  input  wire logic        busTrig,
  input  wire logic        captDone,
  input  wire logic [31:0] taskDone,
  input  wire logic        postDone,
  output logic             readyPin,
  output logic             busTrigReady,
  output logic             busyPin,
  output logic             errorPin,
  output logic             judgeNg,
  output logic             captStart,
  output logic             camCfgLoad,
  output logic [4:0]       captIdx,
  output logic [31:0]      taskRun,
  output logic             postStart,
  output logic             skipPre
);

  // Two-stage synchronisers for pin-side triggers.
  logic [1:0] stepSync_r;
  logic [1:0] trigSync_r;
  logic       stepPrev_r;
  logic       trigPrev_r;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stepSync_r <= 2'h0;
      trigSync_r <= 2'h0;
      stepPrev_r <= 1'b0;
      trigPrev_r <= 1'b0;
    end else begin
      stepSync_r <= {stepSync_r[0], stepPin};
      trigSync_r <= {trigSync_r[0], busTrig};
      stepPrev_r <= stepSync_r[1];
      trigPrev_r <= trigSync_r[1];
    end
  end

  // Only the two documented trigger sources count as steps.
  wire stepEvt = (stepSync_r[1] & ~stepPrev_r) |
                 (trigSync_r[1] & ~trigPrev_r);

  // Configuration and status state.
  logic [13:0]  cfg_r;
  logic [5:0]   tmoSec_r;
  mtcs_state_t  state_r;
  mtcs_state_t  stateNxt;
  logic [4:0]   blk_r;
  logic         auto_r;
  logic         err_r;
  logic         ng_r;
  logic         ready_r;
  logic [31:0]  run_r;
  logic [31:0]  msCnt_r;
  logic [15:0]  msElap_r;
  logic         capt_r;
  logic         post_r;
  logic         camLd_r;
  logic [31:0]  rdata_r;
  logic         busy_r;

  wire [4:0] lastBlk  = cfg_r[MTCS_CFG_NBLK_LSB +: 5];
  wire       parEn    = cfg_r[MTCS_CFG_PAR];
  // Several inputs in a block override the selected multi-input mode.
  wire       multiEff = cfg_r[MTCS_CFG_MULTI] &
                        ~cfg_r[MTCS_CFG_MULTIIN];
  wire [2:0] coreLim  = cfg_r[MTCS_CFG_CORES +: 3];
  wire       isLast   = (blk_r == lastBlk);

  // Register port decode.
  wire wrCtrl = regWr & (regAddr == MTCS_REG_CTRL);
  wire wrCfg  = regWr & (regAddr == MTCS_REG_CFG);
  wire wrTmo  = regWr & (regAddr == MTCS_REG_TMO);
  wire goCmd  = wrCtrl & regWdata[MTCS_CTRL_START];
  wire abort  = wrCtrl & regWdata[MTCS_CTRL_ABORT];
  wire errClr = wrCtrl & regWdata[MTCS_CTRL_ERRCLR];
  wire idle   = (state_r == MTCS_IDLE) | (state_r == MTCS_DONE) |
                (state_r == MTCS_FAIL);
  wire liveMd = cfg_r[MTCS_CFG_LIVE];

  // A command start or live view runs without waiting for steps.
  wire autoGo = idle & (goCmd | (liveMd & ~goCmd));
  wire stepGo = idle & stepEvt & ~liveMd;

  // Running block count for the core limit when executing in parallel.
  logic [5:0] nRun;
  always_comb begin
    nRun = 6'h00;
    for (int i = 0; i < MTCS_MAX_BLOCKS; i++) begin
      nRun = nRun + {5'h00, run_r[i]};
    end
  end
  wire seqBusy = |run_r;
  // Sequential mode waits for the previous block; parallel mode for a core.
  wire slotFree = parEn ? (nRun < {3'h0, coreLim}) : ~seqBusy;

  // Timeout in milliseconds; zero seconds waits for ever here.
  wire [15:0] tmoMs   = 16'(tmoSec_r) * 16'd1000;
  wire        msTick  = (msCnt_r == 32'(MsCycles - 1));
  wire        tmoHit  = (tmoSec_r != 6'h00) & (msElap_r >= tmoMs);
  wire        badStep = stepEvt & ~ready_r & ~idle &
                        (state_r != MTCS_POST);

  // Sequencing state machine.
  always_comb begin
    stateNxt = state_r;
    case (state_r)
      MTCS_IDLE, MTCS_DONE, MTCS_FAIL: begin
        if (autoGo | stepGo) begin
          stateNxt = MTCS_CAPT;
        end
      end
      MTCS_WAIT: begin
        if (badStep) begin
          stateNxt = MTCS_FAIL;
        end else if (tmoHit) begin
          stateNxt = MTCS_FAIL;
        end else if ((auto_r | stepEvt) & slotFree) begin
          stateNxt = MTCS_CAPT;
        end
      end
      MTCS_CAPT: begin
        if (badStep) begin
          stateNxt = MTCS_FAIL;
        end else if (captDone) begin
          stateNxt = isLast ? MTCS_POST : MTCS_WAIT;
        end
      end
      MTCS_POST: begin
        if (postDone) begin
          stateNxt = MTCS_DONE;
        end
      end
      default: stateNxt = MTCS_IDLE;
    endcase
    if (abort) begin
      stateNxt = MTCS_IDLE;
    end
  end

  // Per-block run flags: set on capture done, cleared by task completion.
  genvar g;
  generate
    for (g = 0; g < MTCS_MAX_BLOCKS; g++) begin : gRun
      always_ff @(posedge core_clk) begin
        if (rst) begin
          run_r[g] <= 1'b0;
        end else if (abort | (state_r == MTCS_FAIL)) begin
          run_r[g] <= 1'b0;
        end else if ((state_r == MTCS_CAPT) & captDone &
                     (blk_r == 5'(g))) begin
          run_r[g] <= 1'b1;
        end else if (taskDone[g]) begin
          run_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Main sequencing registers.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r  <= MTCS_IDLE;
      blk_r    <= 5'h00;
      auto_r   <= 1'b0;
      ready_r  <= 1'b0;
      err_r    <= 1'b0;
      ng_r     <= 1'b0;
      capt_r   <= 1'b0;
      camLd_r  <= 1'b0;
      post_r   <= 1'b0;
      msCnt_r  <= 32'h0;
      msElap_r <= 16'h0;
    end else begin
      state_r <= stateNxt;
      capt_r  <= (stateNxt == MTCS_CAPT) & (state_r != MTCS_CAPT);
      // Each input reloads camera settings; under multi-input only the first input of a flow does.
      camLd_r <= (stateNxt == MTCS_CAPT) & (state_r != MTCS_CAPT) &
                 (~multiEff | idle);
      post_r  <= (stateNxt == MTCS_POST) & (state_r != MTCS_POST);
      // Ready in the wait and quiet states, also while no slot is free; drops on the step.
      ready_r <= (stateNxt == MTCS_WAIT) |
                 (idle & (stateNxt != MTCS_CAPT));
      if (idle & (autoGo | stepGo)) begin
        blk_r  <= 5'(MTCS_START_POS);
        auto_r <= autoGo;
        ng_r   <= 1'b0;
      end else if ((state_r == MTCS_CAPT) & (stateNxt == MTCS_WAIT)) begin
        blk_r <= blk_r + 5'h01;
      end
      // Set wins over a clear in the same cycle.
      if (badStep) begin
        err_r <= 1'b1;
      end else if (errClr) begin
        err_r <= 1'b0;
      end
      if ((state_r == MTCS_WAIT) & tmoHit) begin
        ng_r <= 1'b1;
      end
      // Restart the wait count whenever ready is reasserted.
      if (state_r != MTCS_WAIT) begin
        msCnt_r  <= 32'h0;
        msElap_r <= 16'h0;
      end else if (msTick) begin
        msCnt_r  <= 32'h0;
        msElap_r <= msElap_r + 16'h1;
      end else begin
        msCnt_r <= msCnt_r + 32'h1;
      end
    end
  end

  // Busy follows the next state, so the pin comes from a flip-flop and
  // still rises in the same cycle as the state leaves the quiet states.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= (stateNxt != MTCS_IDLE) & (stateNxt != MTCS_DONE) &
                (stateNxt != MTCS_FAIL);
    end
  end

  // Software-written configuration; timeout is clamped to 60 seconds.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_r    <= MTCS_CFG_RST;
      tmoSec_r <= MTCS_TMO_RST_S;
    end else begin
      if (wrCfg) begin
        cfg_r <= regWdata[13:0];
      end
      if (wrTmo) begin
        tmoSec_r <= (regWdata[5:0] > 6'(MTCS_TMO_MAX_S)) ?
                    6'(MTCS_TMO_MAX_S) : regWdata[5:0];
      end
    end
  end

  // Read data stands for one cycle after the read strobe.
  // Status: flags on top, run count, block index, then the one-hot state.
  wire [31:0] statWord = {err_r, ng_r, ready_r, auto_r, nRun, 1'b0,
                          blk_r, 10'h000, state_r};
  wire [31:0] rdMux = (regAddr == MTCS_REG_CFG)  ? {18'h0, cfg_r} :
                      (regAddr == MTCS_REG_STAT) ? statWord :
                      (regAddr == MTCS_REG_TMO)  ? {26'h0, tmoSec_r} :
                      32'h0;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_r <= 32'h0;
    end else begin
      rdata_r <= regRd ? rdMux : 32'h0;
    end
  end

  // Outputs straight from flip-flops; pre-start items are skipped only when the CFG PRE bit is set.
  assign regRdata     = rdata_r;
  assign readyPin     = ready_r;
  assign busTrigReady = ready_r;
  assign busyPin      = busy_r;
  assign errorPin     = err_r;
  assign judgeNg      = ng_r;
  assign captStart    = capt_r;
  assign camCfgLoad   = camLd_r;
  assign captIdx      = blk_r;
  assign taskRun      = run_r;
  assign postStart    = post_r;
  assign skipPre      = cfg_r[MTCS_CFG_PRE];

  // Checks on the design's own behaviour.
  a_ready_drops: assert property (@(posedge core_clk) disable iff (rst)
    (state_r == MTCS_WAIT && stepEvt && slotFree && !tmoHit && ready_r)
    |=> !ready_r) else $error("ready stayed high after a step");
  a_err_on_bad: assert property (@(posedge core_clk) disable iff (rst)
    badStep |=> errorPin) else $error("no error on early step");
  a_bad_fails: assert property (@(posedge core_clk) disable iff (rst)
    (badStep && !abort) |=> state_r == MTCS_FAIL)
    else $error("flow not ended on early step");
  a_wait_noncap: assert property (@(posedge core_clk) disable iff (rst)
    (state_r == MTCS_WAIT && !stepEvt && !auto_r) |=> !captStart)
    else $error("capture without step");
  a_tmo_ng: assert property (@(posedge core_clk) disable iff (rst)
    (state_r == MTCS_WAIT && tmoHit && !badStep && !abort) |=> judgeNg)
    else $error("timeout did not give NG");
  a_blk_order: assert property (@(posedge core_clk) disable iff (rst)
    (state_r == MTCS_CAPT && stateNxt == MTCS_WAIT) |=>
    blk_r == $past(blk_r) + 5'h01) else $error("block skipped");
  a_post_once: assert property (@(posedge core_clk) disable iff (rst)
    (state_r == MTCS_CAPT && captDone && isLast && !badStep && !abort)
    |=> postStart) else $error("post items not started");
  a_seq_limit: assert property (@(posedge core_clk) disable iff (rst)
    (!parEn && state_r == MTCS_WAIT && seqBusy) |=> state_r != MTCS_CAPT)
    else $error("block overlapped in sequential mode");
  a_par_limit: assert property (@(posedge core_clk) disable iff (rst)
    (parEn && coreLim != 3'h0 && nRun >= {3'h0, coreLim}
     && state_r == MTCS_WAIT) |=> state_r != MTCS_CAPT)
    else $error("too many blocks at once");
  a_tmo_restart: assert property (@(posedge core_clk) disable iff (rst)
    $rose(state_r == MTCS_WAIT) |-> msElap_r == 16'h0)
    else $error("wait count not restarted");
  a_capt_noready: assert property (@(posedge core_clk) disable iff (rst)
    captStart |-> !readyPin)
    else $error("ready high during capture");
  a_auto_next: assert property (@(posedge core_clk) disable iff (rst)
    (state_r == MTCS_WAIT && auto_r && slotFree && !tmoHit && !abort)
    |=> state_r == MTCS_CAPT) else $error("auto flow stalled");
  a_live_start: assert property (@(posedge core_clk) disable iff (rst)
    (idle && liveMd && !abort) |=> state_r == MTCS_CAPT)
    else $error("live view did not start the flow");
  a_busy_capt: assert property (@(posedge core_clk) disable iff (rst)
    captStart |-> busyPin)
    else $error("busy low during capture");
endmodule

// File: tb/mtcs_bench.sv
// Self-checking bench for the capture sequencer.
// Assumes the controller model below and a short millisecond of 4 cycles.
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  miscompares++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
`define WAITFOR(c, n) begin k = 0; while (!(c) && k < n) begin \
  @(posedge core_clk); k++; end if (!(c)) begin miscompares++; \
  give_verdict(); end end
module mtcs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import mtcs_pkg::*;
  typedef struct {logic [3:0] a; logic [31:0] d; logic w; logic [31:0] e;}
    mtcs_row_t;
  logic        core_clk, rst, regWr, regRd, stepPin, busTrig, captDone;
  logic [3:0]  regAddr;
  logic [31:0] regWdata, regRdata, taskDone, taskRun, rd;
  logic        postDone, readyPin, busTrigReady, busyPin, errorPin, judgeNg;
  logic        captStart, camCfgLoad, postStart, skipPre;
  logic        stepReq, useBus, rude, slow;
  logic [4:0]  captIdx;
  int          miscompares, total_checks, capCnt, loadCnt, postCnt, k;
  mtcs_row_t   rows [7] = '{
    '{4'h2, 32'h0, 1'b0, 32'h2000_0001},
    '{4'h1, 32'h0, 1'b0, 32'h0000_0042},
    '{4'h3, 32'h0, 1'b0, 32'h0000_000a},
    '{4'h3, 32'h3f, 1'b1, 32'h0000_003c},
    '{4'h3, 32'h05, 1'b1, 32'h0000_0005},
    '{4'h5, 32'h1234, 1'b1, 32'h0},
    '{4'h1, 32'h3fff, 1'b1, 32'h0000_3fff}};

  mtcs_top #(.MsCycles(4)) i_dut (.core_clk(core_clk), .rst(rst),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .stepPin(stepPin), .busTrig(busTrig),
    .captDone(captDone), .taskDone(taskDone), .postDone(postDone),
    .readyPin(readyPin), .busTrigReady(busTrigReady), .busyPin(busyPin),
    .errorPin(errorPin), .judgeNg(judgeNg), .captStart(captStart),
    .camCfgLoad(camCfgLoad), .captIdx(captIdx), .taskRun(taskRun),
    .postStart(postStart), .skipPre(skipPre));
  mtcs_plc_model i_plc (.core_clk(core_clk), .rst(rst),
    .readyPin(readyPin), .busTrigReady(busTrigReady),
    .captStart(captStart), .postStart(postStart), .taskRun(taskRun),
    .stepReq(stepReq), .useBus(useBus), .rude(rude), .slow(slow),
    .stepPin(stepPin), .busTrig(busTrig), .captDone(captDone),
    .taskDone(taskDone), .postDone(postDone));

  // The clock runs at 125 MHz.
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Pulse counters; the bench clears them only while the flow is quiet.
  always @(posedge core_clk) begin
    if (captStart) capCnt++;
    if (camCfgLoad) loadCnt++;
    if (postStart) postCnt++;
  end

  task automatic give_verdict();
    if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wrReg(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample mid-cycle.
  task automatic rdReg(input logic [3:0] a);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(negedge core_clk);
    rd = regRdata;
  endtask

  task automatic doStep(input logic bus, input logic bad);
    @(posedge core_clk);
    stepReq <= 1'b1;
    useBus <= bus;
    rude <= bad;
    `WAITFOR(stepPin | busTrig, 2000)
    @(posedge core_clk);
    stepReq <= 1'b0;
  endtask

  task automatic doReset(input logic [31:0] cfg);
    rst <= 1'b1;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    wrReg(4'h1, cfg);
    capCnt = 0;
    loadCnt = 0;
    postCnt = 0;
  endtask

  initial begin
    {rst, regAddr, regWdata, regWr, regRd} = {1'b1, 38'h0};
    {stepReq, useBus, rude, slow} = 4'h0;
    doReset(32'h41);
    `CHK(readyPin, 1'b1)
    `CHK(errorPin, 1'b0)
    doReset(32'h42);
    foreach (rows[i]) begin
      if (rows[i].w) wrReg(rows[i].a, rows[i].d);
      rdReg(rows[i].a);
      `CHK(rd, rows[i].e)
    end
    `CHK(skipPre, 1'b1)
    // Two blocks by hand: parallel step first, then the fieldbus trigger.
    doReset(32'h41);
    wrReg(4'h3, 32'h0);
    doStep(1'b0, 1'b0);
    `WAITFOR(capCnt == 1, 200)
    `CHK(busyPin, 1'b1)
    `CHK(readyPin, 1'b0)
    `CHK(captIdx, 5'h00)
    `WAITFOR(readyPin, 200)
    repeat (50) @(posedge core_clk);
    `CHK(capCnt, 1)
    `CHK(captIdx, 5'h01)
    doStep(1'b1, 1'b0);
    `WAITFOR(postCnt == 1, 200)
    `CHK(capCnt, 2)
    `CHK(loadCnt, 1)
    // Command start, then live view with several inputs per block.
    for (int m = 0; m < 2; m++) begin
      doReset(m ? 32'h541 : 32'h41);
      // Live view starts by itself; only the command pass needs a write.
      if (m == 0) wrReg(4'h0, 32'h1);
      `WAITFOR(postCnt == 1, 500)
      `CHK(capCnt, 2)
      `CHK(loadCnt, m + 1)
    end
    // A step while not ready ends the flow with the error line up.
    slow <= 1'b1;
    doReset(32'h41);
    doStep(1'b0, 1'b0);
    `WAITFOR(capCnt == 1, 200)
    doStep(1'b0, 1'b1);
    `WAITFOR(errorPin, 200)
    repeat (100) @(posedge core_clk);
    `CHK(capCnt, 1)
    `CHK(postCnt, 0)
    `CHK(busyPin, 1'b0)
    wrReg(4'h0, 32'h4);
    repeat (2) @(posedge core_clk);
    `CHK(errorPin, 1'b0)
    slow <= 1'b0;
    // One second of timeout is 4000 cycles once ready returns.
    doReset(32'h41);
    wrReg(4'h3, 32'h1);
    doStep(1'b0, 1'b0);
    `WAITFOR(capCnt == 1, 200)
    `WAITFOR(readyPin, 200)
    repeat (3990) @(posedge core_clk);
    `CHK(judgeNg, 1'b0)
    `WAITFOR(judgeNg, 40)
    `CHK(judgeNg, 1'b1)
    give_verdict();
  end
endmodule

// File: tb/mtcs_plc_model.sv
// Model of the outside controller that gives step triggers and of the
// capture and task logic that answers the sequencer's pulses.
// Assumes the bench asks for steps through stepReq and holds it until seen.
module mtcs_plc_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        readyPin,
  input  wire logic        busTrigReady,
  input  wire logic        captStart,
  input  wire logic        postStart,
  input  wire logic [31:0] taskRun,
  input  wire logic        stepReq,
  input  wire logic        useBus,
  input  wire logic        rude,
  input  wire logic        slow,
  output logic             stepPin,
  output logic             busTrig,
  output logic             captDone,
  output logic [31:0]      taskDone,
  output logic             postDone
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] hold;
  int         dly;

  // A step line stays high six cycles so the synchroniser sees one edge.
  always @(posedge core_clk) begin
    // One assignment per edge: the pulse comes when the delay runs out.
    captDone <= (dly == 1) && !captStart && !rst;
    postDone <= postStart;
    taskDone <= taskRun & ~taskDone;
    if (rst) begin
      stepPin <= 1'b0;
      busTrig <= 1'b0;
      hold    <= 4'h0;
      dly     <= 0;
    end else begin
      if (stepReq && hold == 4'h0 &&
          (rude || (useBus ? busTrigReady : readyPin))) begin
        hold    <= 4'h6;
        stepPin <= !useBus;
        busTrig <= useBus;
      end else if (hold != 4'h0) begin
        hold <= hold - 4'h1;
        if (hold == 4'h1) begin
          stepPin <= 1'b0;
          busTrig <= 1'b0;
        end
      end
      if (captStart) begin
        dly <= slow ? 30 : 3;
      end else if (dly > 0) begin
        dly      <= dly - 1;
      end
    end
  end
endmodule
